// >>> dv/pid_process_regulator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pid_process_regulator_tb_top
	import pidr_pkg::*;
;
	localparam int TICKS = 20;
	localparam int STEP_V = 7;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ext_en = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b1;
	logic [ADC_W-1:0] v_goal = 12'h000;
	logic [ADC_W-1:0] c_goal = 12'h000;
	logic [ADC_W-1:0] volt;
	logic [ADC_W-1:0] curr;
	logic [31:0] rdata;
	logic [15:0] freq;
	logic active, stby, a_hi, a_lo, d_on;
	logic [16:0] d_val;
	logic [2:0] d_dec;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int dir = 0;
	int moves = 0;
	logic [31:0] seed = 32'h92875a3e;
	logic [31:0] exp_q[$];
	logic rd_p = 1'b0;
	logic mon_en = 1'b0;
	logic [15:0] prev = 16'h0000;
	logic [31:0] rst_tab [13] = '{32'h0, 32'h0, 32'h3e8, 32'h0, 32'h3e8, 32'h3, 32'h0,
		32'ha, 32'h0, 32'h64, 32'h0, 32'h3e8, 32'hc};
	logic [31:0] fmt_tab [4] = '{32'hc, 32'h15, 32'h3, 32'h8};
	logic [16:0] disp_tab [4] = '{17'h7d0, 17'h4e20, 17'hc8, 17'h0};

	always #5 clk = ~clk;

	pidr_sensor_model xmtr (.clk(clk), .slow(slow), .volt_goal(v_goal), .curr_goal(c_goal),
		.volt_out(volt), .curr_out(curr));

	pidr_top #(.TICK_CYCLES(TICKS)) dut (.CORE_CLK(clk), .ARST_N(arst_n), .VOLT_IN(volt),
		.CURR_IN(curr), .EXT_PID_EN(ext_en), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .FREQ_OUT(freq), .PID_ACTIVE(active),
		.STANDBY(stby), .ALARM_HI(a_hi), .ALARM_LO(a_lo), .DISP_ON(d_on),
		.DISP_VALUE(d_val), .DISP_DECIMALS(d_dec));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [31:0] exp_freq(input logic [15:0] p, input int d);
		int f;
		f = int'(p) + d * STEP_V;
		if (f < 0) f = 0;
		if (f > int'(FREQ_MAX_DEF)) f = int'(FREQ_MAX_DEF);
		return 32'(f);
	endfunction : exp_freq

	task automatic close_out();
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] got);
		compares++;
		if (got !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, e, got);
		end
	endtask : chk_reg

	task automatic chk_pin(input string what, input logic e, input logic got);
		compares++;
		if (got !== e) begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, e, got);
		end
	endtask : chk_pin

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg

	task automatic run_dir(input logic [6:0] ctrl, input logic [11:0] v, input logic [11:0] c,
		input int d);
		int m0;
		mon_en <= 1'b0;
		v_goal <= v;
		c_goal <= c;
		wr_reg(REG_CTRL, {25'h0, ctrl});
		repeat (TICKS + 10) @(posedge clk);
		m0 = moves;
		dir <= d;
		mon_en <= 1'b1;
		repeat (4 * TICKS) @(posedge clk);
		mon_en <= 1'b0;
		chk_pin("loop active", 1'b1, active);
		chk_pin("freq moved", 1'b1, moves - m0 >= 2);
	endtask : run_dir

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge clk) begin
		if (rd_p) begin
			if (exp_q.size() == 0) begin
				chk_reg("read queue", 32'h1, 32'h0);
			end else begin
				chk_reg("read data", exp_q.pop_front(), rdata);
			end
		end
		rd_p <= rd;
		if (mon_en && freq !== prev) begin
			moves++;
			chk_reg("freq step", exp_freq(prev, dir), {16'h0000, freq});
		end
		prev <= freq;
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 13; i++) rd_reg(5'(i), rst_tab[i]);
		rd_reg(5'h0d, 32'h0);
		wr_reg(REG_FREQ, 32'h1234);
		rd_reg(REG_FREQ, 32'h0);
		for (int i = 2; i < 12; i++) begin
			seed = lfsr_next(seed);
			wr_reg(5'(i), seed);
			rd_reg(5'(i), {16'h0000, seed[15:0]});
		end
		for (int i = 2; i < 12; i++) wr_reg(5'(i), rst_tab[i]);
		slow <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			wr_reg(REG_CTRL, {25'h0, 2'(s), 5'h00});
			v_goal <= 12'hfff;
			c_goal <= 12'h000;
			repeat (5) @(posedge clk);
			rd_reg(REG_FB, (s == 0 || s == 2) ? 32'h2710 : 32'h0);
			v_goal <= 12'h000;
			c_goal <= 12'hfff;
			repeat (5) @(posedge clk);
			rd_reg(REG_FB, (s == 1 || s == 3) ? 32'h2710 : 32'h0);
		end
		wr_reg(REG_CTRL, 32'h0);
		v_goal <= 12'hfff;
		repeat (5) @(posedge clk);
		chk_pin("upper alarm", 1'b0, a_hi);
		wr_reg(REG_UPPER, 32'h1f4);
		repeat (3) @(posedge clk);
		chk_pin("upper alarm", 1'b1, a_hi);
		chk_pin("lower alarm", 1'b0, a_lo);
		rd_reg(REG_STATUS, 32'h4);
		v_goal <= 12'h000;
		wr_reg(REG_LOWER, 32'h1f4);
		repeat (5) @(posedge clk);
		chk_pin("lower alarm", 1'b1, a_lo);
		chk_pin("upper alarm", 1'b0, a_hi);
		rd_reg(REG_STATUS, 32'h8);
		wr_reg(REG_UPPER, 32'h3e8);
		wr_reg(REG_LOWER, 32'h0);
		v_goal <= 12'hfff;
		wr_reg(REG_DSCALE, 32'hc8);
		for (int k = 0; k < 4; k++) begin
			wr_reg(REG_DFMT, fmt_tab[k]);
			repeat (4) @(posedge clk);
			chk_reg("display value", {15'h0, disp_tab[k]}, {15'h0, d_val});
			chk_reg("display decimals", {29'h0, fmt_tab[k][5:3]}, {29'h0, d_dec});
			chk_pin("display on", k != 3, d_on);
			rd_reg(REG_DISP, {15'h0, disp_tab[k]});
		end
		slow <= 1'b1;
		wr_reg(REG_STEP, 32'h7);
		wr_reg(REG_TARGET, 32'h1388);
		run_dir(7'h01, 12'h000, 12'h000, 1);
		run_dir(7'h29, 12'hfff, 12'h000, 1);
		run_dir(7'h11, 12'h000, 12'hfff, 1);
		run_dir(7'h05, 12'h000, 12'h000, -1);
		run_dir(7'h01, 12'hfff, 12'h000, -1);
		wr_reg(REG_CTRL, 32'h2);
		repeat (5) @(posedge clk);
		chk_pin("ext mode idle", 1'b0, active);
		ext_en <= 1'b1;
		repeat (5) @(posedge clk);
		chk_pin("ext mode run", 1'b1, active);
		wr_reg(REG_SBFREQ, 32'h64);
		wr_reg(REG_SBDUR, 32'h1);
		wr_reg(REG_WAKE, 32'h320);
		wr_reg(REG_CTRL, 32'h1);
		for (int n = 0; n < 60 * TICKS && !stby; n++) @(posedge clk);
		@(posedge clk);
		chk_pin("standby", 1'b1, stby);
		chk_reg("standby freq", 32'h0, {16'h0000, freq});
		chk_pin("loop detached", 1'b0, active);
		repeat (5 * TICKS) @(posedge clk);
		chk_pin("standby held", 1'b1, stby);
		v_goal <= 12'h000;
		for (int n = 0; n < 3 * TICKS && !active; n++) @(posedge clk);
		@(posedge clk);
		chk_pin("woken", 1'b1, active);
		chk_pin("standby left", 1'b0, stby);
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule : pid_process_regulator_tb_top
`default_nettype wire

// >>> dv/pidr_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module pidr_sensor_model
	import pidr_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic slow, // Ramp instead of jump
	input wire logic [ADC_W-1:0] volt_goal, // Wanted voltage code
	input wire logic [ADC_W-1:0] curr_goal, // Wanted current code
	output logic [ADC_W-1:0] volt_out, // Voltage transmitter
	output logic [ADC_W-1:0] curr_out // Current transmitter
);
	// ----------------------------------------
	// Transmitter slew
	// ----------------------------------------
	function automatic logic [ADC_W-1:0] move(input logic [ADC_W-1:0] now,
		input logic [ADC_W-1:0] goal, input logic s);
		if (!s || (goal > now ? goal - now : now - goal) <= 12'h100) begin
			return goal;
		end
		return goal > now ? now + 12'h100 : now - 12'h100;
	endfunction : move

	initial begin
		volt_out = 12'h000;
		curr_out = 12'h000;
	end

	always @(posedge clk) begin
		volt_out <= move(volt_out, volt_goal, slow);
		curr_out <= move(curr_out, curr_goal, slow);
	end
endmodule : pidr_sensor_model
`default_nettype wire

// >>> verilog/pidr_pkg.sv
`default_nettype none
package pidr_pkg;
	// ----------------------------------------
	// Scaling
	// ----------------------------------------
	localparam int ADC_W = 12;
	localparam int PCT_W = 14;
	localparam logic [13:0] PCT_FULL = 14'h2710;
	localparam logic [15:0] PM_SCALE = 16'h000a;
	localparam logic [15:0] PM_FULL = 16'h03e8;
	localparam logic signed [47:0] GAIN_NUM = 48'sh0003e8;
	localparam logic [15:0] FREQ_MAX_DEF = 16'h2ee0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int TICK_MS = 10;
	localparam int CLK_KHZ = 100000;
	localparam int TICK_CYC = TICK_MS * CLK_KHZ;
	localparam logic [15:0] SB_TICKS = 16'h000a;
	localparam logic [15:0] TI_PER_UNIT = 16'h000a;
	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_TARGET = 5'h01;
	localparam logic [4:0] REG_UPPER = 5'h02;
	localparam logic [4:0] REG_LOWER = 5'h03;
	localparam logic [4:0] REG_PBAND = 5'h04;
	localparam logic [4:0] REG_ITIME = 5'h05;
	localparam logic [4:0] REG_DTIME = 5'h06;
	localparam logic [4:0] REG_STEP = 5'h07;
	localparam logic [4:0] REG_SBFREQ = 5'h08;
	localparam logic [4:0] REG_SBDUR = 5'h09;
	localparam logic [4:0] REG_WAKE = 5'h0a;
	localparam logic [4:0] REG_DSCALE = 5'h0b;
	localparam logic [4:0] REG_DFMT = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;
	localparam logic [4:0] REG_FREQ = 5'h11;
	localparam logic [4:0] REG_FB = 5'h12;
	localparam logic [4:0] REG_DISP = 5'h13;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int CTRL_W = 7;
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_POL = 2;
	localparam int CTRL_SP_LSB = 3;
	localparam int CTRL_FB_LSB = 5;
	localparam int DFMT_DIG_LSB = 0;
	localparam int DFMT_DEC_LSB = 3;
	localparam logic [15:0] UPPER_RST = 16'h03e8;
	localparam logic [15:0] PBAND_RST = 16'h03e8;
	localparam logic [15:0] ITIME_RST = 16'h0003;
	localparam logic [15:0] STEP_RST = 16'h000a;
	localparam logic [15:0] SBDUR_RST = 16'h0064;
	localparam logic [15:0] DSCALE_RST = 16'h03e8;
	localparam logic [5:0] DFMT_RST = 6'h0c;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {EN_OFF = 2'b00, EN_ON = 2'b01, EN_EXT = 2'b10} pidr_en_type;
	typedef enum logic [1:0] {SP_DIG = 2'b00, SP_VOLT = 2'b01, SP_CURR = 2'b10} pidr_sp_type;
	typedef enum logic [1:0] {FB_VOLT = 2'b00, FB_CURR = 2'b01, FB_VMC = 2'b10,
		FB_CMV = 2'b11} pidr_fb_type;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01,
		ST_STANDBY = 2'b10} pidr_state_type;
endpackage : pidr_pkg
`default_nettype wire

// >>> verilog/pidr_top.sv
// What this block does
// - Feedback is voltage, current, voltage minus current, or current minus voltage.
// - Digital target spans 0 to 100 percent in 0.01 steps, 100 is 10 V.
// - Upper alarm rises while feedback is above the upper limit, default 100.
// - Lower alarm rises while feedback is below the lower limit, default 0.
// - Full input of either channel reads as 100 percent.
// - Proportional band 0 to 200 percent; a smaller band gives more gain.
// - Integral time 0 to 200 s, default 0.3 s, sets integral strength.
// - Derivative time 0 to 20, default 0; larger reacts more to change.
// - The loop recomputes one frequency increment every 10 ms.
// - Each increment is clamped to the maximum step, default 0.10 Hz.
// - A standby timer runs while frequency is below the standby threshold.
// - Past the standby duration the output stops and the loop detaches.
// - In standby, feedback under wake fraction of set point restarts the loop.
// - Display full scale 0 to 1000 maps to the 10 V level, default 1000.
// - Display digit count 0 to 5, default 4; zero blanks the display.
// - Display shows 0 to 4 decimals, default 1.
// - Enable mode: off, always on, or on while the external input is high.
// - Set point is the digital target, the voltage or the current input.
// - Negative feedback lowers frequency when feedback exceeds the set point.
`timescale 1ns/1ps
`default_nettype none
module pidr_top
	import pidr_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC, // Clocks per control period
	parameter logic [15:0] FREQ_MAX = FREQ_MAX_DEF // Ceiling in 0.01 Hz
) (
	input wire logic CORE_CLK, // System clock
	input wire logic ARST_N, // Asynchronous reset
	input wire logic [ADC_W-1:0] VOLT_IN, // Voltage input sample
	input wire logic [ADC_W-1:0] CURR_IN, // Current input sample
	input wire logic EXT_PID_EN, // External enable terminal
	input wire logic [4:0] REG_ADDR, // Register index
	input wire logic [31:0] REG_WDATA, // Write data
	input wire logic REG_WR, // Write strobe
	input wire logic REG_RD, // Read strobe
	output logic [31:0] REG_RDATA, // Read data
	output logic [15:0] FREQ_OUT, // Frequency, 0.01 Hz
	output logic PID_ACTIVE, // Loop regulating
	output logic STANDBY, // Output stopped
	output logic ALARM_HI, // Upper alarm
	output logic ALARM_LO, // Lower alarm
	output logic DISP_ON, // Display enabled
	output logic [16:0] DISP_VALUE, // Display digits as integer
	output logic [2:0] DISP_DECIMALS // Digits after point
);
	// ----------------------------------------
	// Reset and tick
	// ----------------------------------------
	localparam int TW = $clog2(TICK_CYCLES);
	logic rst_s1_reg, rst_n;
	logic [TW-1:0] tick_cnt_reg;
	logic tick_reg;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_reg <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			rst_s1_reg <= 1'h1;
			rst_n <= rst_s1_reg;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'h0;
		end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'h1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'h1;
			tick_reg <= 1'h0;
		end
	end

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [CTRL_W-1:0] ctrl_reg;
	logic [15:0] target_reg, upper_reg, lower_reg, pband_reg, itime_reg, dtime_reg;
	logic [15:0] step_reg, sbfreq_reg, sbdur_reg, wake_reg, dscale_reg;
	logic [5:0] dfmt_reg;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
			target_reg <= '0;
			upper_reg <= UPPER_RST;
			lower_reg <= '0;
			pband_reg <= PBAND_RST;
			itime_reg <= ITIME_RST;
			dtime_reg <= '0;
			step_reg <= STEP_RST;
			sbfreq_reg <= '0;
			sbdur_reg <= SBDUR_RST;
			wake_reg <= '0;
			dscale_reg <= DSCALE_RST;
			dfmt_reg <= DFMT_RST;
		end else if (REG_WR) begin
			case (REG_ADDR)
				REG_CTRL: ctrl_reg <= REG_WDATA[CTRL_W-1:0];
				REG_TARGET: target_reg <= REG_WDATA[15:0];
				REG_UPPER: upper_reg <= REG_WDATA[15:0];
				REG_LOWER: lower_reg <= REG_WDATA[15:0];
				REG_PBAND: pband_reg <= REG_WDATA[15:0];
				REG_ITIME: itime_reg <= REG_WDATA[15:0];
				REG_DTIME: dtime_reg <= REG_WDATA[15:0];
				REG_STEP: step_reg <= REG_WDATA[15:0];
				REG_SBFREQ: sbfreq_reg <= REG_WDATA[15:0];
				REG_SBDUR: sbdur_reg <= REG_WDATA[15:0];
				REG_WAKE: wake_reg <= REG_WDATA[15:0];
				REG_DSCALE: dscale_reg <= REG_WDATA[15:0];
				REG_DFMT: dfmt_reg <= REG_WDATA[5:0];
				default: ;
			endcase
		end
	end

	pidr_en_type en_mode;
	pidr_sp_type sp_src;
	pidr_fb_type fb_src;
	logic pol, pid_on;
	logic [2:0] dig_cnt, dec_cnt;
	assign en_mode = pidr_en_type'(ctrl_reg[CTRL_EN_LSB +: 2]);
	assign pol = ctrl_reg[CTRL_POL];
	assign sp_src = pidr_sp_type'(ctrl_reg[CTRL_SP_LSB +: 2]);
	assign fb_src = pidr_fb_type'(ctrl_reg[CTRL_FB_LSB +: 2]);
	assign dig_cnt = dfmt_reg[DFMT_DIG_LSB +: 3];
	assign dec_cnt = dfmt_reg[DFMT_DEC_LSB +: 3];
	assign pid_on = (en_mode == EN_ON) || (en_mode == EN_EXT && EXT_PID_EN);

	// ----------------------------------------
	// Scaling helpers
	// ----------------------------------------
	function automatic logic [13:0] to_pct(input logic [ADC_W-1:0] c);
		logic [25:0] p;
		// Full code divides out exactly, so a full input reads as 100 percent
		p = 26'(c) * 26'(PCT_FULL) / 26'((1 << ADC_W) - 1);
		return p[13:0];
	endfunction : to_pct

	function automatic logic [13:0] pm_to_pct(input logic [15:0] x);
		logic [19:0] p;
		p = 20'(x) * 20'(PM_SCALE);
		return (p > 20'(PCT_FULL)) ? PCT_FULL : p[13:0];
	endfunction : pm_to_pct

	function automatic logic [16:0] pow10(input logic [2:0] n);
		case (n)
			3'h0: return 17'h00001;
			3'h1: return 17'h0000a;
			3'h2: return 17'h00064;
			3'h3: return 17'h003e8;
			3'h4: return 17'h02710;
			default: return 17'h186a0;
		endcase
	endfunction : pow10

	// ----------------------------------------
	// Feedback and set point
	// ----------------------------------------
	logic [13:0] v_pct, c_pct, fb_pct, sp_pct, upper_lvl, lower_lvl, wake_lvl;
	logic [29:0] wake_prod;
	assign v_pct = to_pct(VOLT_IN);
	assign c_pct = to_pct(CURR_IN);
	assign upper_lvl = pm_to_pct(upper_reg);
	assign lower_lvl = pm_to_pct(lower_reg);
	assign wake_prod = 30'(sp_pct) * 30'(wake_reg);
	assign wake_lvl = 14'(wake_prod / 30'(PM_FULL));

	always_comb begin
		case (fb_src)
			FB_VOLT: fb_pct = v_pct;
			FB_CURR: fb_pct = c_pct;
			FB_VMC: fb_pct = (v_pct > c_pct) ? v_pct - c_pct : '0;
			default: fb_pct = (c_pct > v_pct) ? c_pct - v_pct : '0;
		endcase
	end

	always_comb begin
		case (sp_src)
			SP_DIG: sp_pct = (target_reg > 16'(PCT_FULL)) ? PCT_FULL : target_reg[13:0];
			SP_VOLT: sp_pct = v_pct;
			default: sp_pct = c_pct;
		endcase
	end

	// ----------------------------------------
	// Incremental PID
	// ----------------------------------------
	logic signed [31:0] e0, e1_reg, e2_reg, de, dd, i_term, s_sum, step_s, inc, f_sum;
	logic signed [47:0] q;
	logic [15:0] freq_new;

	always_comb begin
		e0 = $signed({18'h0, sp_pct}) - $signed({18'h0, fb_pct});
		if (pol) begin
			e0 = -e0;
		end
		de = e0 - e1_reg;
		dd = e0 - (e1_reg <<< 1) + e2_reg;
		i_term = '0;
		if (itime_reg != 16'h0) begin
			i_term = e0 / $signed({16'h0, itime_reg} * {16'h0, TI_PER_UNIT});
		end
		s_sum = de + i_term + dd * $signed({16'h0, dtime_reg});
		step_s = $signed({16'h0, step_reg});
		if (pband_reg == 16'h0) begin
			q = (s_sum > 0) ? 48'(step_s) : ((s_sum < 0) ? -48'(step_s) : '0);
		end else begin
			q = (s_sum * GAIN_NUM) / $signed({32'h0, pband_reg});
		end
		if (q > step_s) begin
			inc = step_s;
		end else if (q < -step_s) begin
			inc = -step_s;
		end else begin
			inc = 32'(q);
		end
		f_sum = $signed({16'h0, FREQ_OUT}) + inc;
		if (f_sum < 0) begin
			freq_new = '0;
		end else if (f_sum > $signed({16'h0, FREQ_MAX})) begin
			freq_new = FREQ_MAX;
		end else begin
			freq_new = f_sum[15:0];
		end
	end

	// ----------------------------------------
	// Run, standby and wake
	// ----------------------------------------
	pidr_state_type st_reg, st_next;
	logic [31:0] sb_cnt_reg, sb_limit;
	logic freq_low, sb_hit;
	assign sb_limit = {16'h0, sbdur_reg} * {16'h0, SB_TICKS};
	assign freq_low = FREQ_OUT < sbfreq_reg;
	assign sb_hit = freq_low && (sb_cnt_reg >= sb_limit);

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: if (pid_on) st_next = ST_RUN;
			ST_RUN: begin
				if (!pid_on) st_next = ST_IDLE;
				else if (tick_reg && sb_hit) st_next = ST_STANDBY;
			end
			ST_STANDBY: begin
				if (!pid_on) st_next = ST_IDLE;
				else if (tick_reg && fb_pct < wake_lvl) st_next = ST_RUN;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_IDLE;
			PID_ACTIVE <= 1'h0;
			STANDBY <= 1'h0;
		end else begin
			st_reg <= st_next;
			PID_ACTIVE <= st_next == ST_RUN;
			STANDBY <= st_next == ST_STANDBY;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sb_cnt_reg <= '0;
		end else if (st_reg != ST_RUN || !freq_low) begin
			sb_cnt_reg <= '0;
		end else if (tick_reg) begin
			sb_cnt_reg <= sb_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FREQ_OUT <= '0;
		end else if (st_reg == ST_RUN && st_next == ST_STANDBY) begin
			FREQ_OUT <= '0;
		end else if (st_reg == ST_RUN && st_next == ST_RUN && tick_reg) begin
			FREQ_OUT <= freq_new;
		end
	end

	// Loop history is dropped whenever the loop is detached
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			e1_reg <= '0;
			e2_reg <= '0;
		end else if (st_reg != ST_RUN) begin
			e1_reg <= '0;
			e2_reg <= '0;
		end else if (tick_reg) begin
			e2_reg <= e1_reg;
			e1_reg <= e0;
		end
	end

	// ----------------------------------------
	// Alarms and display
	// ----------------------------------------
	logic [39:0] disp_raw;
	assign disp_raw = 40'(dscale_reg) * 40'(fb_pct) * 40'(pow10(dec_cnt))
		/ 40'(PCT_FULL);

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ALARM_HI <= 1'h0;
			ALARM_LO <= 1'h0;
		end else begin
			ALARM_HI <= fb_pct > upper_lvl;
			ALARM_LO <= fb_pct < lower_lvl;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			DISP_ON <= 1'h0;
			DISP_VALUE <= '0;
			DISP_DECIMALS <= '0;
		end else begin
			DISP_ON <= dig_cnt != 3'h0;
			DISP_DECIMALS <= dec_cnt;
			DISP_VALUE <= (dig_cnt == 3'h0) ? '0 :
				17'(disp_raw % 40'(pow10(dig_cnt)));
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	logic [31:0] rd_next;
	always_comb begin
		case (REG_ADDR)
			REG_CTRL: rd_next = 32'(ctrl_reg);
			REG_TARGET: rd_next = 32'(target_reg);
			REG_UPPER: rd_next = 32'(upper_reg);
			REG_LOWER: rd_next = 32'(lower_reg);
			REG_PBAND: rd_next = 32'(pband_reg);
			REG_ITIME: rd_next = 32'(itime_reg);
			REG_DTIME: rd_next = 32'(dtime_reg);
			REG_STEP: rd_next = 32'(step_reg);
			REG_SBFREQ: rd_next = 32'(sbfreq_reg);
			REG_SBDUR: rd_next = 32'(sbdur_reg);
			REG_WAKE: rd_next = 32'(wake_reg);
			REG_DSCALE: rd_next = 32'(dscale_reg);
			REG_DFMT: rd_next = 32'(dfmt_reg);
			REG_STATUS: rd_next = 32'({ALARM_LO, ALARM_HI, STANDBY, PID_ACTIVE});
			REG_FREQ: rd_next = 32'(FREQ_OUT);
			REG_FB: rd_next = 32'(fb_pct);
			REG_DISP: rd_next = 32'(DISP_VALUE);
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= '0;
		end else begin
			REG_RDATA <= REG_RD ? rd_next : '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [TW:0] gap_reg;
	logic seen_reg;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= '0;
			seen_reg <= 1'h0;
		end else if (tick_reg) begin
			gap_reg <= '0;
			seen_reg <= 1'h1;
		end else begin
			gap_reg <= gap_reg + 1'h1;
		end
	end

	sequence s_low_run;
		st_reg == ST_RUN && pid_on && tick_reg && freq_low;
	endsequence
	sequence s_stopped;
		FREQ_OUT == 16'h0 && STANDBY && !PID_ACTIVE;
	endsequence

	chk_tick_period: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		tick_reg && seen_reg |-> gap_reg == (TW + 1)'(TICK_CYCLES - 1))
		else $error("control tick spacing wrong");
	chk_step_clamp: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		st_reg == ST_RUN && tick_reg |=> STANDBY ||
		(17'(FREQ_OUT) <= 17'($past(FREQ_OUT)) + 17'(step_reg) &&
		17'(FREQ_OUT) + 17'(step_reg) >= 17'($past(FREQ_OUT))))
		else $error("frequency step above limit");
	chk_alarm_upper: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		fb_pct > upper_lvl |=> ALARM_HI)
		else $error("upper alarm missing");
	chk_alarm_lower: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		fb_pct < lower_lvl |=> ALARM_LO)
		else $error("lower alarm missing");
	chk_standby_entry: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		s_low_run ##0 sb_cnt_reg >= sb_limit |=> s_stopped)
		else $error("standby not entered");
	chk_standby_hold: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		st_reg == ST_STANDBY && pid_on |-> FREQ_OUT == 16'h0)
		else $error("output runs in standby");
	chk_wake_up: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		st_reg == ST_STANDBY && pid_on && tick_reg && fb_pct < wake_lvl
		|=> PID_ACTIVE && !STANDBY)
		else $error("wake not taken");
	chk_disable_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		en_mode == EN_OFF |=> !PID_ACTIVE && !STANDBY)
		else $error("loop active while disabled");
	chk_display_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
		dig_cnt == 3'h0 |=> !DISP_ON && DISP_VALUE == 17'h0)
		else $error("display not blanked");
endmodule : pidr_top
`default_nettype wire
